// ===== include/ubec_pkg.sv
// Package for the endpoint 1 and endpoint 2 control and status block.
// Assumes a Wishbone classic slave with 32-bit data, 8-bit registers in the low lane.
package ubec_pkg;

  // Register byte addresses, one aligned word each.
  localparam logic [7:0] UBEC_EP1_RX_OFF = 8'h00;
  localparam logic [7:0] UBEC_EP1_TX_OFF = 8'h04;
  localparam logic [7:0] UBEC_EP2_RX_OFF = 8'h08;
  localparam logic [7:0] UBEC_EP2_TX_OFF = 8'h0C;
  localparam logic [7:0] UBEC_CTRL_OFF = 8'h10;
  localparam logic [7:0] UBEC_STAT_OFF = 8'h14;

  // Field positions inside the endpoint registers; mode is endpoint 2 receive only, force reset is in control.
  localparam int UBEC_STAT_LSB = 0;
  localparam int UBEC_STAT_MSB = 1;
  localparam int UBEC_TOGGLE_BIT = 2;
  localparam int UBEC_DONE_BIT = 3;
  localparam int UBEC_MODE_LSB = 6;
  localparam int UBEC_MODE_MSB = 7;
  localparam int UBEC_FORCE_RESET_BIT = 0;

  // Handshake status encodings.
  localparam logic [1:0] UBEC_ST_DISABLED = 2'h0;
  localparam logic [1:0] UBEC_ST_STALL = 2'h1;
  localparam logic [1:0] UBEC_ST_NAK = 2'h2;
  localparam logic [1:0] UBEC_ST_VALID = 2'h3;

  // Endpoint 2 transfer modes.
  localparam logic [1:0] UBEC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] UBEC_MODE_UPLOAD = 2'h1;
  localparam logic [1:0] UBEC_MODE_DOWNLOAD = 2'h2;
  localparam logic [1:0] UBEC_MODE_UNDEF = 2'h3;

  // Values after reset.
  localparam logic [7:0] UBEC_REG_RESET = 8'h00;
  localparam logic UBEC_BIT_RESET = 1'b0;

endpackage

// ===== design/ubec_top.sv
// Endpoint 1 receive and transmit, endpoint 2 receive and transmit control and status.
// Assumes a transaction engine on the same clock that reports correct packets, host
// acknowledges and short packets as one-cycle pulses, and two coprocessor buffer levels.
// Engine events arrive on clk_i already, so no input synchronisers stand here.
// The byte counters and the reset interrupt enable live outside; only the event leaves.
//
// Chosen here: the Wishbone interface to the registers and the address map.

`timescale 1ns/1ps

module ubec_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Transaction engine events, one-cycle pulses on clk_i.
  input wire logic usb_reset_i,
  input wire logic ep1_rx_ok_i,
  input wire logic ep1_rx_pid_i,
  input wire logic ep1_tx_ack_i,
  input wire logic ep2_rx_ok_i,
  input wire logic ep2_rx_pid_i,
  input wire logic ep2_rx_short_i,
  input wire logic ep2_tx_ack_i,
  input wire logic ep2_tx_short_i,
  // Coprocessor buffer levels.
  input wire logic ep2_rx_room_i,
  input wire logic ep2_tx_data_i,
  // Endpoint state toward the transaction engine.
  output logic [1:0] ep1_rx_stat_o,
  output logic ep1_rx_toggle_o,
  output logic ep1_rx_transfer_done_o,
  output logic [1:0] ep1_tx_stat_o,
  output logic ep1_tx_toggle_o,
  output logic ep1_tx_transfer_done_o,
  output logic [1:0] ep2_rx_stat_o,
  output logic ep2_rx_toggle_o,
  output logic ep2_rx_transfer_done_o,
  output logic [1:0] ep2_tx_stat_o,
  output logic ep2_tx_toggle_o,
  output logic ep2_tx_transfer_done_o,
  output logic [1:0] ep2_transfer_mode_o,
  output logic usb_if_reset_o,
  output logic usb_reset_event_o
);
  import ubec_pkg::*;

  // Endpoint 1 fields.
  logic [1:0] ep1_rx_stat_q, ep1_rx_stat_d;
  logic ep1_rx_tog_q, ep1_rx_tog_d;
  logic ep1_rx_done_q, ep1_rx_done_d;
  logic [1:0] ep1_tx_stat_q, ep1_tx_stat_d;
  logic ep1_tx_tog_q, ep1_tx_tog_d;
  logic ep1_tx_done_q, ep1_tx_done_d;
  // Endpoint 2 fields and its mode.
  logic [1:0] ep2_rx_stat_q, ep2_rx_stat_d;
  logic ep2_rx_tog_q, ep2_rx_tog_d;
  logic ep2_rx_done_q, ep2_rx_done_d;
  logic [1:0] ep2_tx_stat_q, ep2_tx_stat_d;
  logic ep2_tx_tog_q, ep2_tx_tog_d;
  logic ep2_tx_done_q, ep2_tx_done_d;
  logic [1:0] mode_q, mode_d;
  // Force reset, its release event and the bus answer.
  logic force_bus_reset_q;
  logic reset_event_q;
  logic ack_q;
  logic [31:0] dat_q;

  // Bus decode. A request is taken while ack is low; read data is captured then.
  wire bus_req = cyc_i & stb_i & ~ack_q;
  // A write commits at the edge where the master samples ack, so a cycle that is
  // dropped before the answer leaves the registers untouched.
  wire bus_commit = cyc_i & stb_i & ack_q;
  wire wr_strobe = bus_commit & we_i & sel_i[0];
  wire [7:0] wdat = dat_i[7:0];
  wire wr_ep1_rx = wr_strobe & (adr_i == UBEC_EP1_RX_OFF);
  wire wr_ep1_tx = wr_strobe & (adr_i == UBEC_EP1_TX_OFF);
  wire wr_ep2_rx = wr_strobe & (adr_i == UBEC_EP2_RX_OFF);
  wire wr_ep2_tx = wr_strobe & (adr_i == UBEC_EP2_TX_OFF);
  wire wr_ctrl = wr_strobe & (adr_i == UBEC_CTRL_OFF);

  // Mode value 11 falls through to normal since only 01 and 10 are compared.
  wire mode_upload = (mode_q == UBEC_MODE_UPLOAD);
  wire mode_download = (mode_q == UBEC_MODE_DOWNLOAD);
  // Only one direction can be hardware managed at a time, as the field holds one mode.

  // Received and forced bus resets act alike on the endpoint fields.
  wire bus_reset = usb_reset_i | force_bus_reset_q;
  // The force bit keeps the reset applied for as long as software leaves it set.

  // A repeated packet with the stale PID is not a new transfer.
  wire ep1_rx_good = ep1_rx_ok_i & (ep1_rx_pid_i == ep1_rx_tog_q);
  wire ep2_rx_good = ep2_rx_ok_i & (ep2_rx_pid_i == ep2_rx_tog_q);

  // A short packet ends the hardware-managed burst in either direction.
  wire dl_end = mode_download & ep2_rx_good & ep2_rx_short_i;
  wire ul_end = mode_upload & ep2_tx_ack_i & ep2_tx_short_i;
  wire dl_mid = mode_download & ep2_rx_good & ~ep2_rx_short_i;
  wire ul_mid = mode_upload & ep2_tx_ack_i & ~ep2_tx_short_i;

  // Hardware re-arms the endpoint once the coprocessor buffer is ready.
  wire dl_rearm = mode_download & (ep2_rx_stat_q == UBEC_ST_NAK) & ep2_rx_room_i;
  wire ul_rearm = mode_upload & (ep2_tx_stat_q == UBEC_ST_NAK) & ep2_tx_data_i;
  // Re-arming ignores the byte counters: the buffer levels alone decide readiness.

  // Read values; reserved bits are tied to zero here.
  wire [7:0] rd_ep1_rx = {4'h0, ep1_rx_done_q, ep1_rx_tog_q, ep1_rx_stat_q};
  wire [7:0] rd_ep1_tx = {4'h0, ep1_tx_done_q, ep1_tx_tog_q, ep1_tx_stat_q};
  wire [7:0] rd_ep2_rx = {mode_q, 2'h0, ep2_rx_done_q, ep2_rx_tog_q, ep2_rx_stat_q};
  wire [7:0] rd_ep2_tx = {4'h0, ep2_tx_done_q, ep2_tx_tog_q, ep2_tx_stat_q};
  wire [7:0] rd_ctrl = {7'h00, force_bus_reset_q};
  wire [7:0] rd_stat = {6'h00, ep2_tx_data_i, ep2_rx_room_i};
  // Unmapped addresses read zero; writes to them match no strobe and are dropped.
  wire [7:0] rd_mux =
    (adr_i == UBEC_EP1_RX_OFF) ? rd_ep1_rx :
    (adr_i == UBEC_EP1_TX_OFF) ? rd_ep1_tx :
    (adr_i == UBEC_EP2_RX_OFF) ? rd_ep2_rx :
    (adr_i == UBEC_EP2_TX_OFF) ? rd_ep2_tx :
    (adr_i == UBEC_CTRL_OFF) ? rd_ctrl :
    (adr_i == UBEC_STAT_OFF) ? rd_stat : 8'h00;

  // Each endpoint applies, in this order: software write, hardware event, bus reset.
  // The later assignment wins, so a hardware set beats a same-cycle clear by software
  // and a bus reset beats both on the toggle and status bits.
  // Endpoint 1 receive.
  always_comb begin
    ep1_rx_stat_d = ep1_rx_stat_q;
    ep1_rx_tog_d = ep1_rx_tog_q;
    ep1_rx_done_d = ep1_rx_done_q;
    if (wr_ep1_rx) begin
      ep1_rx_stat_d = wdat[UBEC_STAT_MSB:UBEC_STAT_LSB];
      ep1_rx_tog_d = wdat[UBEC_TOGGLE_BIT];
      ep1_rx_done_d = wdat[UBEC_DONE_BIT];
    end
    // The hardware event is applied after the write so a set is never lost.
    if (ep1_rx_good) begin
      ep1_rx_done_d = 1'b1;
      ep1_rx_tog_d = ~ep1_rx_tog_q;
      ep1_rx_stat_d = UBEC_ST_NAK;
    end
    // Bus reset leaves the done flag alone so a pending event is not lost.
    if (bus_reset) begin
      ep1_rx_stat_d = UBEC_ST_DISABLED;
      ep1_rx_tog_d = UBEC_BIT_RESET;
    end
  end

  // Endpoint 1 transmit.
  always_comb begin
    ep1_tx_stat_d = ep1_tx_stat_q;
    ep1_tx_tog_d = ep1_tx_tog_q;
    ep1_tx_done_d = ep1_tx_done_q;
    if (wr_ep1_tx) begin
      ep1_tx_stat_d = wdat[UBEC_STAT_MSB:UBEC_STAT_LSB];
      ep1_tx_tog_d = wdat[UBEC_TOGGLE_BIT];
      ep1_tx_done_d = wdat[UBEC_DONE_BIT];
    end
    // A host acknowledge beats a same-cycle write, as on the receive side.
    if (ep1_tx_ack_i) begin
      ep1_tx_done_d = 1'b1;
      ep1_tx_tog_d = ~ep1_tx_tog_q;
      ep1_tx_stat_d = UBEC_ST_NAK;
    end
    if (bus_reset) begin
      ep1_tx_stat_d = UBEC_ST_DISABLED;
      ep1_tx_tog_d = UBEC_BIT_RESET;
    end
  end

  // Endpoint 2 receive and the mode field.
  always_comb begin
    ep2_rx_stat_d = ep2_rx_stat_q;
    ep2_rx_tog_d = ep2_rx_tog_q;
    ep2_rx_done_d = ep2_rx_done_q;
    mode_d = mode_q;
    if (wr_ep2_rx) begin
      mode_d = wdat[UBEC_MODE_MSB:UBEC_MODE_LSB];
      ep2_rx_tog_d = wdat[UBEC_TOGGLE_BIT];
      ep2_rx_done_d = wdat[UBEC_DONE_BIT];
      // Status is write protected while download owns it.
      if (!mode_download) begin
        ep2_rx_stat_d = wdat[UBEC_STAT_MSB:UBEC_STAT_LSB];
      end
    end
    if (ep2_rx_good) begin
      ep2_rx_tog_d = ~ep2_rx_tog_q;
      ep2_rx_stat_d = UBEC_ST_NAK;
      // Full packets in download mode raise no done flag.
      if (!dl_mid) begin
        ep2_rx_done_d = 1'b1;
      end
    end else if (dl_rearm) begin
      // Re-arming waits one cycle after the packet, so the NAK is seen first.
      ep2_rx_stat_d = UBEC_ST_VALID;
    end
    if (dl_end || ul_end) begin
      mode_d = UBEC_MODE_NORMAL;
    end
    // Mode and done flags survive a bus reset; only bits 2:0 are cleared.
    if (bus_reset) begin
      ep2_rx_stat_d = UBEC_ST_DISABLED;
      ep2_rx_tog_d = UBEC_BIT_RESET;
    end
  end

  // Endpoint 2 transmit.
  always_comb begin
    ep2_tx_stat_d = ep2_tx_stat_q;
    ep2_tx_tog_d = ep2_tx_tog_q;
    ep2_tx_done_d = ep2_tx_done_q;
    if (wr_ep2_tx) begin
      ep2_tx_tog_d = wdat[UBEC_TOGGLE_BIT];
      ep2_tx_done_d = wdat[UBEC_DONE_BIT];
      if (!mode_upload) begin
        ep2_tx_stat_d = wdat[UBEC_STAT_MSB:UBEC_STAT_LSB];
      end
    end
    if (ep2_tx_ack_i) begin
      ep2_tx_tog_d = ~ep2_tx_tog_q;
      ep2_tx_stat_d = UBEC_ST_NAK;
      // Full packets in upload mode raise no done flag; the burst runs unattended.
      if (!ul_mid) begin
        ep2_tx_done_d = 1'b1;
      end
    end else if (ul_rearm) begin
      // The coprocessor must hold a whole packet before the endpoint offers it again.
      ep2_tx_stat_d = UBEC_ST_VALID;
    end
    if (bus_reset) begin
      ep2_tx_stat_d = UBEC_ST_DISABLED;
      ep2_tx_tog_d = UBEC_BIT_RESET;
    end
  end

  // Endpoint 1 receive register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ep1_rx_stat_q <= UBEC_ST_DISABLED;
      ep1_rx_tog_q <= UBEC_BIT_RESET;
      ep1_rx_done_q <= UBEC_BIT_RESET;
    end else begin
      ep1_rx_stat_q <= ep1_rx_stat_d;
      ep1_rx_tog_q <= ep1_rx_tog_d;
      ep1_rx_done_q <= ep1_rx_done_d;
    end
  end

  // Endpoint 1 transmit register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ep1_tx_stat_q <= UBEC_ST_DISABLED;
      ep1_tx_tog_q <= UBEC_BIT_RESET;
      ep1_tx_done_q <= UBEC_BIT_RESET;
    end else begin
      ep1_tx_stat_q <= ep1_tx_stat_d;
      ep1_tx_tog_q <= ep1_tx_tog_d;
      ep1_tx_done_q <= ep1_tx_done_d;
    end
  end

  // Endpoint 2 receive register and the mode field.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ep2_rx_stat_q <= UBEC_ST_DISABLED;
      ep2_rx_tog_q <= UBEC_BIT_RESET;
      ep2_rx_done_q <= UBEC_BIT_RESET;
      mode_q <= UBEC_MODE_NORMAL;
    end else begin
      ep2_rx_stat_q <= ep2_rx_stat_d;
      ep2_rx_tog_q <= ep2_rx_tog_d;
      ep2_rx_done_q <= ep2_rx_done_d;
      mode_q <= mode_d;
    end
  end

  // Endpoint 2 transmit register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ep2_tx_stat_q <= UBEC_ST_DISABLED;
      ep2_tx_tog_q <= UBEC_BIT_RESET;
      ep2_tx_done_q <= UBEC_BIT_RESET;
    end else begin
      ep2_tx_stat_q <= ep2_tx_stat_d;
      ep2_tx_tog_q <= ep2_tx_tog_d;
      ep2_tx_done_q <= ep2_tx_done_d;
    end
  end

  // Force reset follows software alone; bus resets do not clear it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_bus_reset_q <= UBEC_BIT_RESET;
    end else if (wr_ctrl) begin
      force_bus_reset_q <= wdat[UBEC_FORCE_RESET_BIT];
    end
  end

  // The release event is one pulse at the edge that clears the force bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_event_q <= UBEC_BIT_RESET;
    end else begin
      reset_event_q <= wr_ctrl & force_bus_reset_q & ~wdat[UBEC_FORCE_RESET_BIT];
    end
  end

  // Bus answer: ack rises the cycle after a request is taken and drops one cycle later.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= UBEC_BIT_RESET;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read data holds until the next access, so the master may take it at the ack edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_q <= {24'h00_0000, UBEC_REG_RESET};
    end else if (bus_req) begin
      dat_q <= {24'h00_0000, rd_mux};
    end
  end

  // Every output is a plain copy of a register; nothing combinational leaves.
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign ep1_rx_stat_o = ep1_rx_stat_q;
  assign ep1_rx_toggle_o = ep1_rx_tog_q;
  assign ep1_rx_transfer_done_o = ep1_rx_done_q;
  assign ep1_tx_stat_o = ep1_tx_stat_q;
  assign ep1_tx_toggle_o = ep1_tx_tog_q;
  assign ep1_tx_transfer_done_o = ep1_tx_done_q;
  assign ep2_rx_stat_o = ep2_rx_stat_q;
  assign ep2_rx_toggle_o = ep2_rx_tog_q;
  assign ep2_rx_transfer_done_o = ep2_rx_done_q;
  assign ep2_tx_stat_o = ep2_tx_stat_q;
  assign ep2_tx_toggle_o = ep2_tx_tog_q;
  assign ep2_tx_transfer_done_o = ep2_tx_done_q;
  assign ep2_transfer_mode_o = mode_q;
  assign usb_if_reset_o = force_bus_reset_q;
  assign usb_reset_event_o = reset_event_q;

endmodule // ubec_top

// ===== verification/ubec_monitor.sv
// Checker for the endpoint control block, bound to its top module.
// Assumes engine events are one-cycle pulses sampled on clk_i.
`timescale 1ns/1ps
module ubec_monitor
  import ubec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic usb_reset_i,
  input wire logic usb_if_reset_o,
  input wire logic ep1_rx_ok_i,
  input wire logic ep1_rx_pid_i,
  input wire logic ep1_tx_ack_i,
  input wire logic ep2_rx_room_i,
  input wire logic usb_reset_event_o,
  input wire logic ep2_rx_ok_i,
  input wire logic ep2_rx_pid_i,
  input wire logic ep2_rx_short_i,
  input wire logic ep2_tx_ack_i,
  input wire logic ep2_tx_short_i,
  input wire logic ep1_rx_toggle_o,
  input wire logic ep1_rx_transfer_done_o,
  input wire logic ep1_tx_toggle_o,
  input wire logic ep1_tx_transfer_done_o,
  input wire logic ep2_rx_toggle_o,
  input wire logic ep2_rx_transfer_done_o,
  input wire logic [1:0] ep1_rx_stat_o,
  input wire logic [1:0] ep1_tx_stat_o,
  input wire logic [1:0] ep2_rx_stat_o,
  input wire logic [1:0] ep2_transfer_mode_o
);
  wire hw_rst = usb_reset_i | usb_if_reset_o;
  wire sw_wr = cyc_i & stb_i & we_i;
  wire dl = ep2_transfer_mode_o == UBEC_MODE_DOWNLOAD;
  wire rx1_hit = ep1_rx_ok_i && ep1_rx_pid_i == ep1_rx_toggle_o && !hw_rst;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_reset_clear_a: assert property (
    hw_rst |=> {ep1_rx_stat_o, ep1_rx_toggle_o, ep1_tx_stat_o, ep1_tx_toggle_o,
    ep2_rx_stat_o, ep2_rx_toggle_o} == 9'h000) else $error("bus reset left fields set");
  rx_done_set_a: assert property (
    rx1_hit |=> ep1_rx_transfer_done_o && ep1_rx_stat_o == UBEC_ST_NAK)
    else $error("receive done or NAK missing");
  rx_toggle_flip_a: assert property (
    rx1_hit |=> ep1_rx_toggle_o != $past(ep1_rx_toggle_o)) else $error("rx toggle kept");
  rx_toggle_hold_a: assert property (
    ep1_rx_ok_i && ep1_rx_pid_i != ep1_rx_toggle_o && !hw_rst && !sw_wr
    |=> $stable(ep1_rx_toggle_o)) else $error("rx toggle moved on retry");
  tx_toggle_cause_a: assert property (
    ep1_tx_toggle_o != $past(ep1_tx_toggle_o) |-> $past(ep1_tx_ack_i | sw_wr | hw_rst))
    else $error("tx toggle moved without cause");
  tx_done_set_a: assert property (
    ep1_tx_ack_i && !hw_rst |=> ep1_tx_transfer_done_o && ep1_tx_stat_o == UBEC_ST_NAK)
    else $error("transmit done or NAK missing");
  dl_rearm_a: assert property (
    dl && ep2_rx_stat_o == UBEC_ST_NAK && ep2_rx_room_i && !ep2_rx_ok_i && !hw_rst && !sw_wr
    |=> ep2_rx_stat_o == UBEC_ST_VALID) else $error("download not re-armed");
  dl_no_done_a: assert property (
    dl && ep2_rx_ok_i && !ep2_rx_short_i && !ep2_rx_transfer_done_o && !sw_wr
    |=> !ep2_rx_transfer_done_o) else $error("done set on full download packet");
  dl_short_end_a: assert property (
    dl && ep2_rx_ok_i && ep2_rx_short_i && ep2_rx_pid_i == ep2_rx_toggle_o && !hw_rst && !sw_wr
    |=> ep2_transfer_mode_o == UBEC_MODE_NORMAL && ep2_rx_transfer_done_o
    && ep2_rx_stat_o == UBEC_ST_NAK) else $error("short packet did not end download");
  force_event_a: assert property (
    usb_reset_event_o == $fell(usb_if_reset_o)) else $error("reset event mistimed");
  dl_short_c: cover property (dl && ep2_rx_ok_i && ep2_rx_short_i);
  up_short_c: cover property (ep2_transfer_mode_o == UBEC_MODE_UPLOAD && ep2_tx_ack_i
    && ep2_tx_short_i);
  force_c: cover property (usb_reset_event_o);
endmodule // ubec_monitor

bind ubec_top ubec_monitor ubec_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .usb_reset_i(usb_reset_i), .usb_if_reset_o(usb_if_reset_o), .ep1_rx_ok_i(ep1_rx_ok_i),
  .ep1_rx_pid_i(ep1_rx_pid_i), .ep1_tx_ack_i(ep1_tx_ack_i), .ep2_rx_room_i(ep2_rx_room_i),
  .usb_reset_event_o(usb_reset_event_o), .ep2_rx_ok_i(ep2_rx_ok_i),
  .ep2_rx_pid_i(ep2_rx_pid_i), .ep2_rx_short_i(ep2_rx_short_i), .ep2_tx_ack_i(ep2_tx_ack_i),
  .ep2_tx_short_i(ep2_tx_short_i), .ep1_rx_toggle_o(ep1_rx_toggle_o),
  .ep1_rx_transfer_done_o(ep1_rx_transfer_done_o), .ep1_tx_toggle_o(ep1_tx_toggle_o),
  .ep1_tx_transfer_done_o(ep1_tx_transfer_done_o), .ep2_rx_toggle_o(ep2_rx_toggle_o),
  .ep2_rx_transfer_done_o(ep2_rx_transfer_done_o), .ep1_rx_stat_o(ep1_rx_stat_o),
  .ep1_tx_stat_o(ep1_tx_stat_o), .ep2_rx_stat_o(ep2_rx_stat_o),
  .ep2_transfer_mode_o(ep2_transfer_mode_o)
);

// ===== verification/ubec_host_model.sv
// Host side model: turns bench requests into one-cycle engine event pulses.
// Assumes one request at a time, issued from the bench's main sequence.
`timescale 1ns/1ps
module ubec_host_model (
  input wire logic clk_i,
  output logic bus_rst_o,
  output logic e1_ok_o,
  output logic e1_pid_o,
  output logic e1_ack_o,
  output logic e2_ok_o,
  output logic e2_pid_o,
  output logic e2_sh_o,
  output logic e2_ack_o,
  output logic e2_tsh_o
);
  initial {bus_rst_o, e1_ok_o, e1_ack_o, e2_ok_o, e2_ack_o} = '0;
  initial {e1_pid_o, e2_pid_o, e2_sh_o, e2_tsh_o} = '0;
  // Kind 0 bus reset, 1 ep1 OUT, 2 ep1 IN ack, 3 ep2 OUT, 4 ep2 IN ack; gap slows the host.
  task automatic send(input int kind, input logic pid, input logic sh, input int gap);
    repeat (gap + 1) @(posedge clk_i);
    {e1_pid_o, e2_pid_o, e2_sh_o, e2_tsh_o} <= {pid, pid, sh, sh};
    case (kind)
      0: bus_rst_o <= 1'b1;
      1: e1_ok_o <= 1'b1;
      2: e1_ack_o <= 1'b1;
      3: e2_ok_o <= 1'b1;
      default: e2_ack_o <= 1'b1;
    endcase
    @(posedge clk_i);
    {bus_rst_o, e1_ok_o, e1_ack_o, e2_ok_o, e2_ack_o} <= '0;
    // Released qualifiers do not hold their value, so a design that reads them late fails.
    {e1_pid_o, e2_pid_o, e2_sh_o, e2_tsh_o} <= ~{pid, pid, sh, sh};
  endtask
endmodule // ubec_host_model

// ===== verification/tb_top.sv
// Self-checking bench for the endpoint control block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb_top;
  import ubec_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, room, data_lv;
  logic bus_rst, e1_ok, e1_pid, e1_ack, e2_ok, e2_pid, e2_sh, e2_ack, e2_tsh;
  logic [1:0] p1rs, p1ts, p2rs, p2ts, pmode;
  logic p1rt, p1rd, p1tt, p1td, p2rt, p2rd, p2tt, p2td, pif, pev;
  int ev_cnt = 0;
  logic [7:0] adr_i, rd, ad;
  logic [31:0] dat_i, dat_o, seed;
  int error_cnt = 0;
  int total_checks = 0;
  ubec_top ubec_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .usb_reset_i(bus_rst),
    .ep1_rx_ok_i(e1_ok), .ep1_rx_pid_i(e1_pid), .ep1_tx_ack_i(e1_ack), .ep2_rx_ok_i(e2_ok),
    .ep2_rx_pid_i(e2_pid), .ep2_rx_short_i(e2_sh), .ep2_tx_ack_i(e2_ack),
    .ep2_tx_short_i(e2_tsh), .ep2_rx_room_i(room), .ep2_tx_data_i(data_lv),
    .ep1_rx_stat_o(p1rs), .ep1_rx_toggle_o(p1rt), .ep1_rx_transfer_done_o(p1rd),
    .ep1_tx_stat_o(p1ts), .ep1_tx_toggle_o(p1tt), .ep1_tx_transfer_done_o(p1td),
    .ep2_rx_stat_o(p2rs), .ep2_rx_toggle_o(p2rt), .ep2_rx_transfer_done_o(p2rd),
    .ep2_tx_stat_o(p2ts), .ep2_tx_toggle_o(p2tt), .ep2_tx_transfer_done_o(p2td),
    .ep2_transfer_mode_o(pmode), .usb_if_reset_o(pif), .usb_reset_event_o(pev)
  );
  ubec_host_model host_inst (
    .clk_i(clk_i), .bus_rst_o(bus_rst), .e1_ok_o(e1_ok), .e1_pid_o(e1_pid), .e1_ack_o(e1_ack),
    .e2_ok_o(e2_ok), .e2_pid_o(e2_pid), .e2_sh_o(e2_sh), .e2_ack_o(e2_ack), .e2_tsh_o(e2_tsh)
  );
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // The release event stands one cycle, so each pulse is seen at exactly one edge.
  always @(posedge clk_i) begin
    if (pev === 1'b1) begin
      ev_cnt++;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] ep1_view(input logic [7:0] v);
    return v & 8'h0F;
  endfunction
  // Endpoint pins packed like their register, so one expected value serves both.
  function automatic logic [7:0] pin_view(input logic [7:0] a);
    case (a)
      UBEC_EP1_RX_OFF: return {4'h0, p1rd, p1rt, p1rs};
      UBEC_EP1_TX_OFF: return {4'h0, p1td, p1tt, p1ts};
      UBEC_EP2_RX_OFF: return {pmode, 2'h0, p2rd, p2rt, p2rs};
      UBEC_EP2_TX_OFF: return {4'h0, p2td, p2tt, p2ts};
      default: return {7'h00, pif};
    endcase
  endfunction
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read data is taken at the edge that samples ack, before that edge's updates land.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    // A missing answer counts once and the sequence runs on to the closing report.
    if (ack_o !== 1'b1) begin
      error_cnt++;
    end
    rd = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, e);
    if (a <= UBEC_CTRL_OFF) begin
      chk(pin_view(a), e);
    end
  endtask
  initial begin
    {cyc_i, stb_i, we_i, room, data_lv} = '0;
    {adr_i, dat_i} = '0;
    seed = 32'h7A286DBB;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h18; a += 4) rc(a[7:0], 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      ad = i[0] ? UBEC_EP1_TX_OFF : UBEC_EP1_RX_OFF;
      wr(ad, seed[7:0]);
      rc(ad, ep1_view(seed[7:0]));
      wr(UBEC_EP2_RX_OFF, seed[15:8] & 8'h7F);
      rc(UBEC_EP2_RX_OFF, seed[15:8] & 8'h4F);
    end
    wr(UBEC_EP2_RX_OFF, 8'hC3);
    host_inst.send(3, 1'b0, 1'b0, 0);
    rc(UBEC_EP2_RX_OFF, 8'hCE);
    wr(UBEC_EP1_RX_OFF, 8'h03);
    host_inst.send(1, 1'b0, 1'b0, 0);
    rc(UBEC_EP1_RX_OFF, 8'h0E);
    host_inst.send(1, 1'b0, 1'b0, 3);
    rc(UBEC_EP1_RX_OFF, 8'h0E);
    wr(UBEC_EP1_TX_OFF, 8'h03);
    host_inst.send(2, 1'b0, 1'b0, 0);
    rc(UBEC_EP1_TX_OFF, 8'h0E);
    wr(UBEC_EP1_TX_OFF, 8'h01);
    rc(UBEC_EP1_TX_OFF, 8'h01);
    wr(UBEC_EP2_RX_OFF, 8'h03);
    wr(UBEC_EP2_RX_OFF, 8'h83);
    host_inst.send(3, 1'b0, 1'b0, 2);
    rc(UBEC_EP2_RX_OFF, 8'h86);
    room <= 1'b1;
    rc(UBEC_EP2_RX_OFF, 8'h87);
    wr(UBEC_EP2_RX_OFF, 8'h84);
    rc(UBEC_EP2_RX_OFF, 8'h87);
    host_inst.send(3, 1'b1, 1'b1, 0);
    rc(UBEC_EP2_RX_OFF, 8'h0A);
    wr(UBEC_EP2_TX_OFF, 8'h02);
    wr(UBEC_EP2_RX_OFF, 8'h40);
    data_lv <= 1'b1;
    rc(UBEC_EP2_TX_OFF, 8'h03);
    wr(UBEC_EP2_TX_OFF, 8'h04);
    rc(UBEC_EP2_TX_OFF, 8'h07);
    host_inst.send(4, 1'b0, 1'b0, 0);
    rc(UBEC_EP2_TX_OFF, 8'h03);
    data_lv <= 1'b0;
    host_inst.send(4, 1'b0, 1'b1, 1);
    rc(UBEC_EP2_TX_OFF, 8'h0E);
    rc(UBEC_EP2_RX_OFF, 8'h00);
    wr(UBEC_EP1_TX_OFF, 8'h0F);
    host_inst.send(0, 1'b0, 1'b0, 0);
    rc(UBEC_EP1_TX_OFF, 8'h08);
    wr(UBEC_CTRL_OFF, 8'h01);
    rc(UBEC_CTRL_OFF, 8'h01);
    wr(UBEC_EP1_RX_OFF, 8'h07);
    rc(UBEC_EP1_RX_OFF, 8'h00);
    wr(UBEC_CTRL_OFF, 8'h00);
    rc(UBEC_CTRL_OFF, 8'h00);
    chk(ev_cnt[7:0], 8'h01);
    print_verdict();
  end
endmodule // tb_top
